// >>> pkg/hir_pkg.sv
/*
 * shared constants for the hdlc interrupt-mask and receive-information bank:
 * register offsets, bit positions, sticky masks and reset values.
 * assumes an 8-bit parallel control port with byte offsets as printed.
 */
`default_nettype none

package hir_pkg;

   // ==========================================================
   // port widths
   localparam int unsigned HIR_ADDR_W = 8;   // control port address width
   localparam int unsigned HIR_DATA_W = 8;   // control port data width

   // ==========================================================
   // register offsets on the control port
   localparam logic [HIR_ADDR_W-1:0] HIR_OFS_STATUS = 8'h01;  // hdlc_status_flags
   localparam logic [HIR_ADDR_W-1:0] HIR_OFS_ENABLE = 8'h02;  // hdlc_interrupt_enable
   localparam logic [HIR_ADDR_W-1:0] HIR_OFS_RXINFO = 8'h03;  // hdlc_receive_info

   // ==========================================================
   // hdlc_status_flags / hdlc_interrupt_enable bit positions
   localparam int unsigned HIR_ST_BOC    = 7;  // boc_change_flag
   localparam int unsigned HIR_ST_PEND   = 6;  // rx_packet_end
   localparam int unsigned HIR_ST_PSTART = 5;  // rx_packet_start
   localparam int unsigned HIR_ST_RX_FIFO_HALF_FULL  = 4;  // rx_fifo_half_full
   localparam int unsigned HIR_ST_RNE    = 3;  // rx_fifo_not_empty
   localparam int unsigned HIR_ST_TX_FIFO_HALF_EMPTY  = 2;  // tx_fifo_half_empty
   localparam int unsigned HIR_ST_TNF    = 1;  // tx_fifo_not_full
   localparam int unsigned HIR_ST_TX_MESSAGE_END  = 0;  // tx_message_end

   // ==========================================================
   // hdlc_receive_info bit positions
   localparam int unsigned HIR_RI_ABT   = 7;  // rx_abort_seen
   localparam int unsigned HIR_RI_CRC   = 6;  // rx_crc_error
   localparam int unsigned HIR_RI_OVR   = 5;  // rx_overrun
   localparam int unsigned HIR_RI_VM    = 4;  // rx_valid_message
   localparam int unsigned HIR_RI_EMPTY = 3;  // rx_fifo_empty
   localparam int unsigned HIR_RI_POK   = 2;  // packet_good_tag
   localparam int unsigned HIR_RI_CLOSING_BYTE_TAG = 1;  // closing_byte_tag
   localparam int unsigned HIR_RI_OPENING_BYTE_TAG = 0;  // opening_byte_tag

   // ==========================================================
   // which bits latch (1) and which follow live inputs (0)
   localparam logic [HIR_DATA_W-1:0] HIR_STATUS_STICKY = 8'hE1;
   localparam logic [HIR_DATA_W-1:0] HIR_RXINFO_STICKY = 8'hF0;

   // ==========================================================
   // reset and idle values
   localparam logic [HIR_DATA_W-1:0] HIR_ENABLE_RST = 8'h00;  // all sources masked
   localparam logic [HIR_DATA_W-1:0] HIR_ZERO_BYTE  = 8'h00;  // unmapped read value

endpackage : hir_pkg

`default_nettype wire

// >>> verilog/hir_sticky_bank.sv
/*
 * bank of status bits: selected bits latch their set pulses until a
 * clear strobe, the others pass their live level through.
 * assumes set inputs come from logic on core_clk.
 */
`default_nettype none

module hir_sticky_bank
   import hir_pkg::*;
#(
   parameter int unsigned              W      = HIR_DATA_W,  // bank width
   parameter logic [W-1:0]             STICKY = '0           // latched bits
) (
   input  wire logic         core_clk,  // system clock
   input  wire logic         rst,       // async reset, active high
   input  wire logic [W-1:0] set_vec,   // event pulses / live levels
   input  wire logic         clr,       // clear-on-read strobe
   output logic      [W-1:0] view       // register view
);

   // ==========================================================
   // latched state
   logic [W-1:0] flag_reg;   // sticky bits
   logic [W-1:0] flag_next;  // next sticky bits

   // set wins over clear so an event in the read cycle is kept
   always_comb begin
      flag_next = flag_reg;
      if (clr) begin
         flag_next = '0;
      end
      flag_next = STICKY & (flag_next | set_vec);
   end

   // register only
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         flag_reg <= '0;
      end else begin
         flag_reg <= flag_next;
      end
   end

   // live bits bypass the flops so they are never stale
   assign view = (flag_reg & STICKY) | (set_vec & ~STICKY);

   // ==========================================================
   // checks
   property p_bank_set_wins;
      @(posedge core_clk) disable iff (rst)
      (clr && |(set_vec & STICKY)) |=> ((flag_reg & $past(set_vec & STICKY)) == $past(set_vec & STICKY));
   endproperty
   a_bank_set_wins : assert property (p_bank_set_wins) else $error("sticky set lost to clear");

endmodule : hir_sticky_bank

`default_nettype wire

// >>> verilog/hir_irq_rxinfo.sv
/*
 * hdlc interrupt mask, status flags and receive-information register.
 * assumes the parallel port front end delivers one-cycle read and write
 * strobes on core_clk, and that the hdlc engine, fifo and boc detector
 * deliver event pulses and levels on core_clk.
 */
`default_nettype none

module hir_irq_rxinfo
   import hir_pkg::*;
(
   input  wire logic                  core_clk,            // system clock
   input  wire logic                  rst,                 // async reset, active high
   // control port
   input  wire logic [HIR_ADDR_W-1:0] host_addr,           // register offset
   input  wire logic [HIR_DATA_W-1:0] host_wdata,          // write data
   input  wire logic                  host_wr,             // write strobe
   input  wire logic                  host_rd,             // read strobe
   output logic      [HIR_DATA_W-1:0] host_rdata,          // read data
   // hdlc engine events, one-cycle pulses
   input  wire logic                  boc_change_evt,      // boc detector change
   input  wire logic                  rx_start_evt,        // opening byte seen
   input  wire logic                  rx_valid_evt,        // checked good packet
   input  wire logic                  rx_abort_evt,        // seven or more ones
   input  wire logic                  rx_crc_err_evt,      // bad checksum
   input  wire logic                  rx_overrun_evt,      // write into full fifo
   input  wire logic                  tx_msg_end_evt,      // transmit message done
   // fifo levels
   input  wire logic                  rx_fifo_half_full,   // rx past halfway
   input  wire logic                  rx_fifo_not_empty,   // rx holds a byte
   input  wire logic                  tx_fifo_half_empty,  // tx below halfway
   input  wire logic                  tx_fifo_not_full,    // tx has room
   // tags of the byte at the rx fifo head
   input  wire logic                  head_first,          // first of message
   input  wire logic                  head_last,           // last of message
   input  wire logic                  head_good,           // message valid
   output logic                       hdlc_irq             // interrupt, active high
);

   // ==========================================================
   // address decode
   logic rd_status;  // read of hdlc_status_flags
   logic rd_rxinfo;  // read of hdlc_receive_info
   logic wr_enable;  // write of hdlc_interrupt_enable

   always_comb begin
      rd_status = host_rd && (host_addr == HIR_OFS_STATUS);
      rd_rxinfo = host_rd && (host_addr == HIR_OFS_RXINFO);
      wr_enable = host_wr && (host_addr == HIR_OFS_ENABLE);
   end

   // ==========================================================
   // status flag sources
   logic                  pkt_end_evt;  // any way a message can finish
   logic [HIR_DATA_W-1:0] status_set;   // pulses and live levels
   logic [HIR_DATA_W-1:0] status_view;  // hdlc_status_flags

   // aborts, crc faults and overruns all end the packet as well
   always_comb begin
      pkt_end_evt = rx_valid_evt | rx_crc_err_evt | rx_overrun_evt | rx_abort_evt;
      status_set               = HIR_ZERO_BYTE;
      status_set[HIR_ST_BOC]    = boc_change_evt;
      status_set[HIR_ST_PEND]   = pkt_end_evt;
      status_set[HIR_ST_PSTART] = rx_start_evt;
      status_set[HIR_ST_RX_FIFO_HALF_FULL]  = rx_fifo_half_full;
      status_set[HIR_ST_RNE]    = rx_fifo_not_empty;
      status_set[HIR_ST_TX_FIFO_HALF_EMPTY]  = tx_fifo_half_empty;
      status_set[HIR_ST_TNF]    = tx_fifo_not_full;
      status_set[HIR_ST_TX_MESSAGE_END]  = tx_msg_end_evt;
   end

   // event bits latch and drop on a read of the status register
   hir_sticky_bank #(
      .W      (HIR_DATA_W),
      .STICKY (HIR_STATUS_STICKY)
   ) u_status (
      .core_clk (core_clk),
      .rst      (rst),
      .set_vec  (status_set),
      .clr      (rd_status),
      .view     (status_view)
   );

   // ==========================================================
   // receive information sources
   logic                  head_valid;   // a byte is available at the head
   logic [HIR_DATA_W-1:0] rxinfo_set;   // pulses and live levels
   logic [HIR_DATA_W-1:0] rxinfo_view;  // hdlc_receive_info

   // tags only mean something while a byte sits at the head
   always_comb begin
      head_valid = rx_fifo_not_empty;
      rxinfo_set               = HIR_ZERO_BYTE;
      rxinfo_set[HIR_RI_ABT]   = rx_abort_evt;
      rxinfo_set[HIR_RI_CRC]   = rx_crc_err_evt;
      rxinfo_set[HIR_RI_OVR]   = rx_overrun_evt;
      rxinfo_set[HIR_RI_VM]    = rx_valid_evt;
      rxinfo_set[HIR_RI_EMPTY] = ~rx_fifo_not_empty;
      rxinfo_set[HIR_RI_POK]   = head_valid & head_last & head_good;
      rxinfo_set[HIR_RI_CLOSING_BYTE_TAG] = head_valid & head_last;
      rxinfo_set[HIR_RI_OPENING_BYTE_TAG] = head_valid & head_first;
   end

   // four fault/valid bits latch, the rest are live
   hir_sticky_bank #(
      .W      (HIR_DATA_W),
      .STICKY (HIR_RXINFO_STICKY)
   ) u_rxinfo (
      .core_clk (core_clk),
      .rst      (rst),
      .set_vec  (rxinfo_set),
      .clr      (rd_rxinfo),
      .view     (rxinfo_view)
   );

   // ==========================================================
   // mask, read data and interrupt
   logic [HIR_DATA_W-1:0] enable_reg;   // hdlc_interrupt_enable
   logic [HIR_DATA_W-1:0] enable_next;
   logic [HIR_DATA_W-1:0] rdata_reg;    // captured read data
   logic [HIR_DATA_W-1:0] rdata_next;
   logic                  irq_reg;      // registered interrupt
   logic                  irq_next;

   // next values; read data is the pre-clear view of the same cycle
   always_comb begin
      enable_next = enable_reg;
      if (wr_enable) begin
         enable_next = host_wdata;
      end
      rdata_next = rdata_reg;
      if (host_rd) begin
         unique case (host_addr)
            HIR_OFS_STATUS: begin
               rdata_next = status_view;
            end
            HIR_OFS_ENABLE: begin
               rdata_next = enable_reg;
            end
            HIR_OFS_RXINFO: begin
               rdata_next = rxinfo_view;
            end
            default: begin
               rdata_next = HIR_ZERO_BYTE;          // not held here
            end
         endcase
      end
      // 1 in a mask bit lets that source through
      irq_next = |(status_view & enable_reg);
   end

   // register only
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         enable_reg <= HIR_ENABLE_RST;
         rdata_reg  <= HIR_ZERO_BYTE;
         irq_reg    <= 1'b0;
      end else begin
         enable_reg <= enable_next;
         rdata_reg  <= rdata_next;
         irq_reg    <= irq_next;
      end
   end

   // outputs from flops; irq trails the flags by one cycle
   assign host_rdata = rdata_reg;
   assign hdlc_irq   = irq_reg;

   // ==========================================================
   // checks
   property p_status_clear;
      @(posedge core_clk) disable iff (rst)
      (rd_status && !(|(status_set & HIR_STATUS_STICKY))) |=> ((status_view & HIR_STATUS_STICKY) == HIR_ZERO_BYTE);
   endproperty
   a_status_clear : assert property (p_status_clear) else $error("status events not cleared");

   property p_mask_write;
      @(posedge core_clk) disable iff (rst)
      // mask of the cycle before, so a back-to-back write cannot skew the compare
      wr_enable |=> (enable_reg == $past(host_wdata))
         ##1 (hdlc_irq == |($past(status_view) & $past(enable_reg)));
   endproperty
   a_mask_write : assert property (p_mask_write) else $error("mask write not applied");

   property p_abort;
      @(posedge core_clk) disable iff (rst)
      rx_abort_evt |=> rxinfo_view[HIR_RI_ABT];
   endproperty
   a_abort : assert property (p_abort) else $error("abort flag not set");

   property p_crc;
      @(posedge core_clk) disable iff (rst)
      rx_crc_err_evt |=> rxinfo_view[HIR_RI_CRC] && status_view[HIR_ST_PEND];
   endproperty
   a_crc : assert property (p_crc) else $error("crc flag not set");

   property p_ovr;
      @(posedge core_clk) disable iff (rst)
      rx_overrun_evt |=> rxinfo_view[HIR_RI_OVR];
   endproperty
   a_ovr : assert property (p_ovr) else $error("overrun flag not set");

   property p_vm;
      @(posedge core_clk) disable iff (rst)
      rx_valid_evt |=> rxinfo_view[HIR_RI_VM];
   endproperty
   a_vm : assert property (p_vm) else $error("valid message flag not set");

   property p_pok_read;
      @(posedge core_clk) disable iff (rst)
      rd_rxinfo |=> host_rdata[HIR_RI_POK] == $past(rx_fifo_not_empty && head_last && head_good);
   endproperty
   a_pok_read : assert property (p_pok_read) else $error("packet good tag wrong");

   property p_closing_byte_tag_read;
      @(posedge core_clk) disable iff (rst)
      rd_rxinfo |=> host_rdata[HIR_RI_CLOSING_BYTE_TAG] == $past(rx_fifo_not_empty && head_last);
   endproperty
   a_closing_byte_tag_read : assert property (p_closing_byte_tag_read) else $error("closing tag wrong");

   property p_opening_byte_tag_read;
      @(posedge core_clk) disable iff (rst)
      rd_rxinfo |=> host_rdata[HIR_RI_OPENING_BYTE_TAG] == $past(rx_fifo_not_empty && head_first);
   endproperty
   a_opening_byte_tag_read : assert property (p_opening_byte_tag_read) else $error("opening tag wrong");

   property p_rxinfo_clear;
      @(posedge core_clk) disable iff (rst)
      (rd_rxinfo && !(|(rxinfo_set & HIR_RXINFO_STICKY))) |=> ((rxinfo_view & HIR_RXINFO_STICKY) == HIR_ZERO_BYTE);
   endproperty
   a_rxinfo_clear : assert property (p_rxinfo_clear) else $error("rx info not cleared");

   property p_pkt_end;
      @(posedge core_clk) disable iff (rst)
      (rx_valid_evt || rx_abort_evt || rx_overrun_evt) |=> status_view[HIR_ST_PEND];
   endproperty
   a_pkt_end : assert property (p_pkt_end) else $error("packet end not raised");

   property p_empty_read;
      @(posedge core_clk) disable iff (rst)
      rd_rxinfo |=> host_rdata[HIR_RI_EMPTY] == !$past(rx_fifo_not_empty);
   endproperty
   a_empty_read : assert property (p_empty_read) else $error("empty bit wrong");

   property p_irq;
      @(posedge core_clk) disable iff (rst)
      ##1 (hdlc_irq == |($past(status_view) & $past(enable_reg)));
   endproperty
   a_irq : assert property (p_irq) else $error("interrupt disagrees with flags");

   property p_boc;
      @(posedge core_clk) disable iff (rst)
      boc_change_evt |=> status_view[HIR_ST_BOC];
   endproperty
   a_boc : assert property (p_boc) else $error("boc change flag not set");

   property p_status_live;
      @(posedge core_clk) disable iff (rst)
      (status_view[HIR_ST_RX_FIFO_HALF_FULL] == rx_fifo_half_full) && (status_view[HIR_ST_RNE] == rx_fifo_not_empty)
         && (status_view[HIR_ST_TX_FIFO_HALF_EMPTY] == tx_fifo_half_empty) && (status_view[HIR_ST_TNF] == tx_fifo_not_full);
   endproperty
   a_status_live : assert property (p_status_live) else $error("live status bits stale");

   property p_rdata_hold;
      @(posedge core_clk) disable iff (rst)
      !host_rd |=> $stable(host_rdata);
   endproperty
   a_rdata_hold : assert property (p_rdata_hold) else $error("read data moved without a read");

   property p_enable_hold;
      @(posedge core_clk) disable iff (rst)
      !wr_enable |=> $stable(enable_reg);
   endproperty
   a_enable_hold : assert property (p_enable_hold) else $error("mask changed without a write");

   property p_unmapped_read;
      @(posedge core_clk) disable iff (rst)
      (host_rd && (host_addr != HIR_OFS_STATUS) && (host_addr != HIR_OFS_ENABLE) && (host_addr != HIR_OFS_RXINFO))
         |=> (host_rdata == HIR_ZERO_BYTE);
   endproperty
   a_unmapped_read : assert property (p_unmapped_read) else $error("unmapped read not zero");

   property p_empty_live;
      @(posedge core_clk) disable iff (rst)
      rxinfo_view[HIR_RI_EMPTY] == !rx_fifo_not_empty;
   endproperty
   a_empty_live : assert property (p_empty_live) else $error("empty bit not live");

   property p_tags_gated;
      @(posedge core_clk) disable iff (rst)
      !rx_fifo_not_empty |-> !(rxinfo_view[HIR_RI_POK] || rxinfo_view[HIR_RI_CLOSING_BYTE_TAG] || rxinfo_view[HIR_RI_OPENING_BYTE_TAG]);
   endproperty
   a_tags_gated : assert property (p_tags_gated) else $error("head tags shown with empty fifo");

   // main scenarios
   c_irq_raised   : cover property (@(posedge core_clk) disable iff (rst) $rose(hdlc_irq));
   c_mask_write   : cover property (@(posedge core_clk) disable iff (rst)
                                    wr_enable && (host_wdata != HIR_ENABLE_RST));
   c_read_clear   : cover property (@(posedge core_clk) disable iff (rst)
                                    rd_rxinfo && rxinfo_view[HIR_RI_ABT]);
   c_set_on_clear : cover property (@(posedge core_clk) disable iff (rst)
                                    rd_status && tx_msg_end_evt);
   c_good_close   : cover property (@(posedge core_clk) disable iff (rst)
                                    rd_rxinfo && head_last && head_good && rx_fifo_not_empty);

endmodule : hir_irq_rxinfo

`default_nettype wire

// >>> tb/hir_irq_rxinfo_bench.sv
/*
 * self-checking bench for the hdlc interrupt-mask and receive-information
 * bank: reset values, mask access, clear-on-read flags, live bits, head tags
 * and the interrupt output.
 * assumes the design of hir_irq_rxinfo with its own embedded assertions and
 * one-cycle host strobes; every input is driven at the falling clock edge.
 */
`default_nettype none

module hir_irq_rxinfo_bench
   import hir_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // stimulus and observed signals
   logic                  core_clk;      // 250 MHz system clock
   logic                  rst;           // async reset, active high
   logic [HIR_ADDR_W-1:0] host_addr;     // register offset
   logic [HIR_DATA_W-1:0] host_wdata;    // write data
   logic                  host_wr;       // write strobe
   logic                  host_rd;       // read strobe
   logic [HIR_DATA_W-1:0] host_rdata;    // read data
   logic [6:0]            evt;           // event pulses, one bit per source
   logic [3:0]            lvl;           // fifo levels
   logic                  head_first;    // head byte opens a message
   logic                  head_last;     // head byte closes a message
   logic                  head_good;     // head message checked good
   logic                  hdlc_irq;      // interrupt output
   int                    failures;      // mismatches seen
   int                    n_compared;    // comparisons made
   logic [7:0]            rv;            // last read value

   // ==========================================================
   // device under test
   hir_irq_rxinfo u_hir_irq_rxinfo (
      .core_clk           (core_clk),
      .rst                (rst),
      .host_addr          (host_addr),
      .host_wdata         (host_wdata),
      .host_wr            (host_wr),
      .host_rd            (host_rd),
      .host_rdata         (host_rdata),
      .boc_change_evt     (evt[0]),
      .rx_start_evt       (evt[1]),
      .rx_valid_evt       (evt[2]),
      .rx_abort_evt       (evt[3]),
      .rx_crc_err_evt     (evt[4]),
      .rx_overrun_evt     (evt[5]),
      .tx_msg_end_evt     (evt[6]),
      .rx_fifo_half_full  (lvl[0]),
      .rx_fifo_not_empty  (lvl[1]),
      .tx_fifo_half_empty (lvl[2]),
      .tx_fifo_not_full   (lvl[3]),
      .head_first         (head_first),
      .head_last          (head_last),
      .head_good          (head_good),
      .hdlc_irq           (hdlc_irq)
   );

   // ==========================================================
   // clock
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // ==========================================================
   // shared tasks
   // compare and count; four-state equality so x never matches
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic print_verdict();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : print_verdict

   // one read strobe; data is registered at the taking edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge core_clk);
      host_addr = a;
      host_rd   = 1'b1;
      @(negedge core_clk);
      host_rd   = 1'b0;
      d         = host_rdata;
   endtask : rd

   // read and compare in one step
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      rd(a, rv);
      check(rv, exp);
   endtask : rd_chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      host_addr  = a;
      host_wdata = d;
      host_wr    = 1'b1;
      @(negedge core_clk);
      host_wr    = 1'b0;
   endtask : wr

   // one-cycle pulse on event source i
   task automatic pulse(input int i);
      @(negedge core_clk);
      evt[i] = 1'b1;
      @(negedge core_clk);
      evt    = 7'h00;
   endtask : pulse

   // bounded wait for the interrupt level; a timeout shows as a mismatch
   task automatic wait_irq(input logic v);
      for (int k = 0; k < 4 && hdlc_irq !== v; k++) begin
         @(negedge core_clk);
      end
      check({7'h00, hdlc_irq}, {7'h00, v});
   endtask : wait_irq

   // ==========================================================
   // scenarios
   // reset values, one unmapped offset and a write to the info register
   task automatic sc_reset_map();
      rd_chk(HIR_OFS_ENABLE, 8'h00);
      rd_chk(HIR_OFS_STATUS, 8'h00);
      rd_chk(HIR_OFS_RXINFO, 8'h08);
      wr(HIR_OFS_RXINFO, 8'hFF);
      rd_chk(HIR_OFS_RXINFO, 8'h08);
      rd_chk(8'h07, 8'h00);
      check({7'h00, hdlc_irq}, 8'h00);
   endtask : sc_reset_map

   // mask holds both alternating patterns
   task automatic sc_mask_rw();
      wr(HIR_OFS_ENABLE, 8'hA5);
      rd_chk(HIR_OFS_ENABLE, 8'hA5);
      wr(HIR_OFS_ENABLE, 8'h5A);
      rd_chk(HIR_OFS_ENABLE, 8'h5A);
      wr(HIR_OFS_ENABLE, 8'h00);
   endtask : sc_mask_rw

   // status events latch and clear on read, one by one
   task automatic sc_status_sticky();
      logic [7:0] st[3] = '{8'h80, 8'h20, 8'h01};
      int         ix[3] = '{0, 1, 6};
      for (int i = 0; i < 3; i++) begin
         pulse(ix[i]);
         repeat (3) @(negedge core_clk);  // latched, not a live level
         rd_chk(HIR_OFS_STATUS, st[i]);
         rd_chk(HIR_OFS_STATUS, 8'h00);
      end
   endtask : sc_status_sticky

   // each receive outcome sets its info flag and packet end
   task automatic sc_rx_outcomes();
      logic [7:0] ri[4] = '{8'h10, 8'h80, 8'h40, 8'h20};
      for (int i = 0; i < 4; i++) begin
         pulse(i + 2);
         rd_chk(HIR_OFS_RXINFO, ri[i] | 8'h08);
         rd_chk(HIR_OFS_RXINFO, 8'h08);
         rd_chk(HIR_OFS_STATUS, 8'h40);
         rd_chk(HIR_OFS_STATUS, 8'h00);
      end
   endtask : sc_rx_outcomes

   // an event arriving with the clearing read must not be lost
   task automatic sc_set_wins();
      @(negedge core_clk);
      host_addr = HIR_OFS_RXINFO;
      host_rd   = 1'b1;
      evt[3]    = 1'b1;
      @(negedge core_clk);
      host_rd   = 1'b0;
      evt       = 7'h00;
      check(host_rdata, 8'h08);
      rd_chk(HIR_OFS_RXINFO, 8'h88);
      rd_chk(HIR_OFS_RXINFO, 8'h08);
      rd_chk(HIR_OFS_STATUS, 8'h40);
   endtask : sc_set_wins

   // live fifo levels and head tags
   task automatic sc_live_bits();
      lvl = 4'hF;
      rd_chk(HIR_OFS_STATUS, 8'h1E);
      lvl = 4'h2;
      head_first = 1'b1;
      rd_chk(HIR_OFS_RXINFO, 8'h01);
      head_first = 1'b0;
      head_last  = 1'b1;
      head_good  = 1'b1;
      rd_chk(HIR_OFS_RXINFO, 8'h06);
      head_good  = 1'b0;
      rd_chk(HIR_OFS_RXINFO, 8'h02);
      lvl = 4'h0;
      rd_chk(HIR_OFS_RXINFO, 8'h08);
      rd_chk(HIR_OFS_STATUS, 8'h00);
      head_last  = 1'b0;
   endtask : sc_live_bits

   // masked flag stays quiet, enabling raises the line, reading drops it
   task automatic sc_interrupt();
      pulse(6);
      repeat (3) @(negedge core_clk);
      check({7'h00, hdlc_irq}, 8'h00);
      wr(HIR_OFS_ENABLE, 8'h01);
      wait_irq(1'b1);
      rd_chk(HIR_OFS_STATUS, 8'h01);
      wait_irq(1'b0);
      wr(HIR_OFS_ENABLE, 8'h08);
      lvl = 4'h2;
      wait_irq(1'b1);
      lvl = 4'h0;
      wait_irq(1'b0);
      wr(HIR_OFS_ENABLE, 8'h00);
   endtask : sc_interrupt

   // ==========================================================
   // watchdog against a hang
   initial begin
      repeat (100000) @(posedge core_clk);
      failures++;
      print_verdict();
   end

   // ==========================================================
   // main sequence
   initial begin
      failures   = 0;
      n_compared = 0;
      rst        = 1'b1;
      host_addr  = 8'h00;
      host_wdata = 8'h00;
      host_wr    = 1'b0;
      host_rd    = 1'b0;
      evt        = 7'h00;
      lvl        = 4'h0;
      head_first = 1'b0;
      head_last  = 1'b0;
      head_good  = 1'b0;
      repeat (20) @(negedge core_clk);
      rst = 1'b0;
      sc_reset_map();
      sc_mask_rw();
      sc_status_sticky();
      sc_rx_outcomes();
      sc_set_wins();
      sc_live_bits();
      sc_interrupt();
      print_verdict();
   end

endmodule : hir_irq_rxinfo_bench

`default_nettype wire
